// ==== rtl/lctp_pkg.sv ====
/*
 * lctp_pkg: register map, field positions, reset values and offsets shared by
 * the lcd timing and palette block. Assumes a 32-bit APB register bus.
 */
package lctp_pkg;
    // register byte offsets
    localparam logic [7:0] LCTP_OFS_PANEL_CFG  = 8'h0c;
    localparam logic [7:0] LCTP_OFS_STATUS     = 8'h14;
    localparam logic [7:0] LCTP_OFS_PAL_WRITE  = 8'h18;
    localparam logic [7:0] LCTP_OFS_PAL_READ   = 8'h1c;
    localparam logic [7:0] LCTP_OFS_HTOTAL     = 8'h20;
    localparam logic [7:0] LCTP_OFS_HDISP_W    = 8'h24;
    localparam logic [7:0] LCTP_OFS_HDISP_S    = 8'h28;
    localparam logic [7:0] LCTP_OFS_LSYNC      = 8'h2c;
    localparam logic [7:0] LCTP_OFS_VTOTAL     = 8'h30;
    localparam logic [7:0] LCTP_OFS_VDISP_H    = 8'h34;
    localparam logic [7:0] LCTP_OFS_VDISP_S    = 8'h38;
    localparam logic [7:0] LCTP_OFS_FSYNC      = 8'h3c;

    // palette geometry
    localparam int LCTP_PAL_DEPTH = 256;
    localparam int LCTP_PAL_AW    = 8;
    localparam int LCTP_PAL_DW    = 6;

    // palette word field positions
    localparam int LCTP_IDX_LSB   = 24;
    localparam int LCTP_RED_LSB   = 18;
    localparam int LCTP_GRN_LSB   = 10;
    localparam int LCTP_BLU_LSB   = 2;
    localparam int LCTP_LANE_IDX  = 3;
    localparam int LCTP_LANE_BLU  = 0;

    // timing field positions
    localparam int LCTP_POL_BIT    = 23;
    localparam int LCTP_LSW_LSB    = 16;
    localparam int LCTP_FSW_LSB    = 16;
    localparam int LCTP_HFIELD_W   = 7;
    localparam int LCTP_VFIELD_W   = 10;
    localparam int LCTP_FSW_W      = 3;
    localparam int LCTP_VND_BIT    = 7;
    localparam int LCTP_STRAP_BIT  = 0;

    // panel config fields
    localparam int LCTP_CFG_PASSIVE_BIT = 0;
    localparam int LCTP_CFG_TYPE_LSB    = 4;

    // horizontal offsets in pixels
    localparam logic [10:0] LCTP_HOFS_PASSIVE = 11'h016;
    localparam logic [10:0] LCTP_HOFS_ACTIVE  = 11'h005;
    localparam logic [10:0] LCTP_LSYNC_OFS    = 11'h001;

    // strap capture delay, covers the two synchroniser stages
    localparam logic [1:0]  LCTP_STRAP_WAIT   = 2'h2;

    localparam logic [31:0] LCTP_RESET_WORD   = 32'h0000_0000;

    typedef enum logic [1:0] {
        LCTP_TFT_STD,
        LCTP_TFT_TYPE2,
        LCTP_TFT_TYPE3,
        LCTP_TFT_REFLECT
    } lctp_panel_e;
endpackage

// ==== rtl/lctp_palette.sv ====
/*
 * lctp_palette: three colour palettes with one shared write port and one
 * combinational read port. Assumes writes and reads come from one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module lctp_palette
    import lctp_pkg::*;
(
    // clock
    input  wire logic                      clk,
    // write port
    input  wire logic                      wr_en,
    input  wire logic [LCTP_PAL_AW-1:0]    wr_idx,
    input  wire logic [3*LCTP_PAL_DW-1:0]  wr_rgb,
    // read port
    input  wire logic [LCTP_PAL_AW-1:0]    rd_idx,
    output logic      [3*LCTP_PAL_DW-1:0]  rd_rgb
);
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1)
        begin : g_chan
            logic [LCTP_PAL_DW-1:0] mem [LCTP_PAL_DEPTH];
            always_ff @(posedge clk)
            begin
                if (wr_en)
                begin
                    mem[wr_idx] <= wr_rgb[ch*LCTP_PAL_DW +: LCTP_PAL_DW];
                end
            end
            assign rd_rgb[ch*LCTP_PAL_DW +: LCTP_PAL_DW] = mem[rd_idx];
        end
    endgenerate
endmodule
`default_nettype wire

// ==== rtl/lctp_top.sv ====
/*
 * lctp_top: APB register file, palette host access and raster timing
 * generator for an lcd panel. Assumes one clock for bus and pixel logic and an
 * APB master that keeps its request stable through the access phase.
 */
`timescale 1ns/10ps
`default_nettype none
module lctp_top
    import lctp_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // strap pin
    input  wire logic        byte_order_strap,
    // panel timing outputs
    output logic             line_sync_out,
    output logic             frame_sync_out,
    output logic             display_enable,
    output logic             vert_nondisplay
);
    // configuration registers
    logic [31:0]            pal_stage_r;
    logic [LCTP_PAL_AW-1:0] pal_rd_idx_r;
    logic                   cfg_passive_r;
    lctp_panel_e            cfg_type_r;
    logic [6:0]             horiz_total_r;
    logic [6:0]             horiz_display_width_r;
    logic [9:0]             horiz_display_start_r;
    logic                   line_sync_pol_r;
    logic [6:0]             line_sync_width_r;
    logic [9:0]             line_sync_start_r;
    logic [9:0]             vert_total_r;
    logic [9:0]             vert_display_height_r;
    logic [9:0]             vert_display_start_r;
    logic                   frame_sync_pol_r;
    logic [2:0]             frame_sync_width_r;
    logic [9:0]             frame_sync_start_r;

    // strap capture
    logic                   strap_s1_r;
    logic                   strap_s2_r;
    logic [1:0]             strap_wait_r;
    logic                   strap_done_r;
    logic                   big_endian_r;

    // bus decode
    logic                   wr_acc;
    logic                   setup;
    logic                   addr_hit;
    logic [31:0]            rd_word;
    logic [31:0]            wr_merge;
    logic                   pal_commit;
    logic [31:0]            pal_word;
    logic [3*LCTP_PAL_DW-1:0] pal_rd_rgb;

    // counters and compares
    logic [9:0]             hcount_r;
    logic [9:0]             vcount_r;
    logic [9:0]             h_last;
    logic                   h_wrap;
    logic [10:0]            hds;
    logic [11:0]            hde;
    logic [10:0]            ls_beg;
    logic [11:0]            hpe;
    logic [10:0]            vde;
    logic [10:0]            vpe;
    logic                   h_active;
    logic                   v_active;
    logic                   ls_active;
    logic                   fs_active;
    logic                   ls_pol_used;
    logic                   fs_pol_used;

    function automatic logic [31:0] lctp_strb_merge(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite && addr_hit;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    always_comb
    begin
        addr_hit = 1'b1;
        rd_word  = LCTP_RESET_WORD;
        unique case (paddr)
            LCTP_OFS_PANEL_CFG:
            begin
                rd_word[LCTP_CFG_PASSIVE_BIT] = cfg_passive_r;
                rd_word[LCTP_CFG_TYPE_LSB +: 2] = cfg_type_r;
            end
            LCTP_OFS_STATUS:
            begin
                rd_word[LCTP_VND_BIT]   = vert_nondisplay;
                rd_word[LCTP_STRAP_BIT] = big_endian_r;
            end
            LCTP_OFS_PAL_WRITE: rd_word = LCTP_RESET_WORD;
            LCTP_OFS_PAL_READ:
            begin
                // index field is write-only and reads as zero
                rd_word[LCTP_RED_LSB +: LCTP_PAL_DW] = pal_rd_rgb[2*LCTP_PAL_DW +: LCTP_PAL_DW];
                rd_word[LCTP_GRN_LSB +: LCTP_PAL_DW] = pal_rd_rgb[LCTP_PAL_DW +: LCTP_PAL_DW];
                rd_word[LCTP_BLU_LSB +: LCTP_PAL_DW] = pal_rd_rgb[0 +: LCTP_PAL_DW];
            end
            LCTP_OFS_HTOTAL:   rd_word[0 +: LCTP_HFIELD_W] = horiz_total_r;
            LCTP_OFS_HDISP_W:  rd_word[0 +: LCTP_HFIELD_W] = horiz_display_width_r;
            LCTP_OFS_HDISP_S:  rd_word[0 +: LCTP_VFIELD_W] = horiz_display_start_r;
            LCTP_OFS_LSYNC:
            begin
                rd_word[LCTP_POL_BIT] = line_sync_pol_r;
                rd_word[LCTP_LSW_LSB +: LCTP_HFIELD_W] = line_sync_width_r;
                rd_word[0 +: LCTP_VFIELD_W] = line_sync_start_r;
            end
            LCTP_OFS_VTOTAL:   rd_word[0 +: LCTP_VFIELD_W] = vert_total_r;
            LCTP_OFS_VDISP_H:  rd_word[0 +: LCTP_VFIELD_W] = vert_display_height_r;
            LCTP_OFS_VDISP_S:  rd_word[0 +: LCTP_VFIELD_W] = vert_display_start_r;
            LCTP_OFS_FSYNC:
            begin
                rd_word[LCTP_POL_BIT] = frame_sync_pol_r;
                rd_word[LCTP_FSW_LSB +: LCTP_FSW_W] = frame_sync_width_r;
                rd_word[0 +: LCTP_VFIELD_W] = frame_sync_start_r;
            end
            default: addr_hit = 1'b0;
        endcase
    end

    // read data is latched in the setup phase so it is stable in the access phase
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prdata <= LCTP_RESET_WORD;
        end
        else if (setup && !pwrite)
        begin
            prdata <= rd_word;
        end
    end

    // byte-lane merge against the current value of the addressed register
    assign wr_merge = lctp_strb_merge(rd_word, pwdata, pstrb);

    // strap: two flops, then captured once after reset release
    always_ff @(posedge clk)
    begin
        strap_s1_r <= byte_order_strap;
        strap_s2_r <= strap_s1_r;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            strap_wait_r <= 2'h0;
            strap_done_r <= 1'b0;
            big_endian_r <= 1'b0;
        end
        else if (!strap_done_r)
        begin
            if (strap_wait_r == LCTP_STRAP_WAIT)
            begin
                strap_done_r <= 1'b1;
                big_endian_r <= strap_s2_r;
            end
            else
            begin
                strap_wait_r <= strap_wait_r + 2'h1;
            end
        end
    end

    // palette staging and commit
    assign pal_word = lctp_strb_merge(pal_stage_r, pwdata, pstrb);
    assign pal_commit = wr_acc && (paddr == LCTP_OFS_PAL_WRITE) &&
                        (big_endian_r ? pstrb[LCTP_LANE_BLU] : pstrb[LCTP_LANE_IDX]);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pal_stage_r  <= LCTP_RESET_WORD;
            pal_rd_idx_r <= '0;
        end
        else if (wr_acc && paddr == LCTP_OFS_PAL_WRITE)
        begin
            pal_stage_r <= pal_word;
            if (pstrb[LCTP_LANE_IDX])
            begin
                pal_rd_idx_r <= pwdata[LCTP_IDX_LSB +: LCTP_PAL_AW];
            end
        end
        else if (wr_acc && paddr == LCTP_OFS_PAL_READ && pstrb[LCTP_LANE_IDX])
        begin
            pal_rd_idx_r <= pwdata[LCTP_IDX_LSB +: LCTP_PAL_AW];
        end
    end

    lctp_palette u_palette (
        .clk    (clk),
        .wr_en  (pal_commit),
        .wr_idx (pal_word[LCTP_IDX_LSB +: LCTP_PAL_AW]),
        .wr_rgb ({pal_word[LCTP_RED_LSB +: LCTP_PAL_DW],
                  pal_word[LCTP_GRN_LSB +: LCTP_PAL_DW],
                  pal_word[LCTP_BLU_LSB +: LCTP_PAL_DW]}),
        .rd_idx (pal_rd_idx_r),
        .rd_rgb (pal_rd_rgb)
    );

    // panel configuration
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cfg_passive_r <= 1'b0;
            cfg_type_r    <= LCTP_TFT_STD;
        end
        else if (wr_acc && paddr == LCTP_OFS_PANEL_CFG)
        begin
            cfg_passive_r <= wr_merge[LCTP_CFG_PASSIVE_BIT];
            cfg_type_r    <= lctp_panel_e'(wr_merge[LCTP_CFG_TYPE_LSB +: 2]);
        end
    end

    // horizontal timing registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            horiz_total_r         <= '0;
            horiz_display_width_r <= '0;
            horiz_display_start_r <= '0;
            line_sync_pol_r       <= 1'b0;
            line_sync_width_r     <= '0;
            line_sync_start_r     <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr == LCTP_OFS_HTOTAL)
            begin
                horiz_total_r <= wr_merge[0 +: LCTP_HFIELD_W];
            end
            if (paddr == LCTP_OFS_HDISP_W)
            begin
                horiz_display_width_r <= wr_merge[0 +: LCTP_HFIELD_W];
            end
            if (paddr == LCTP_OFS_HDISP_S)
            begin
                horiz_display_start_r <= wr_merge[0 +: LCTP_VFIELD_W];
            end
            if (paddr == LCTP_OFS_LSYNC)
            begin
                line_sync_pol_r   <= wr_merge[LCTP_POL_BIT];
                line_sync_width_r <= wr_merge[LCTP_LSW_LSB +: LCTP_HFIELD_W];
                line_sync_start_r <= wr_merge[0 +: LCTP_VFIELD_W];
            end
        end
    end

    // vertical timing registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            vert_total_r          <= '0;
            vert_display_height_r <= '0;
            vert_display_start_r  <= '0;
            frame_sync_pol_r      <= 1'b0;
            frame_sync_width_r    <= '0;
            frame_sync_start_r    <= '0;
        end
        else if (wr_acc)
        begin
            if (paddr == LCTP_OFS_VTOTAL)
            begin
                vert_total_r <= wr_merge[0 +: LCTP_VFIELD_W];
            end
            if (paddr == LCTP_OFS_VDISP_H)
            begin
                vert_display_height_r <= wr_merge[0 +: LCTP_VFIELD_W];
            end
            if (paddr == LCTP_OFS_VDISP_S)
            begin
                vert_display_start_r <= wr_merge[0 +: LCTP_VFIELD_W];
            end
            if (paddr == LCTP_OFS_FSYNC)
            begin
                frame_sync_pol_r   <= wr_merge[LCTP_POL_BIT];
                frame_sync_width_r <= wr_merge[LCTP_FSW_LSB +: LCTP_FSW_W];
                frame_sync_start_r <= wr_merge[0 +: LCTP_VFIELD_W];
            end
        end
    end

    // last pixel of a line is total*8+7, i.e. field with three low ones
    assign h_last = {horiz_total_r, 3'h7};
    assign h_wrap = (hcount_r == h_last);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hcount_r <= '0;
            vcount_r <= '0;
        end
        else if (h_wrap)
        begin
            hcount_r <= '0;
            if (vcount_r == vert_total_r)
            begin
                vcount_r <= '0;
            end
            else
            begin
                vcount_r <= vcount_r + 10'h001;
            end
        end
        else
        begin
            hcount_r <= hcount_r + 10'h001;
        end
    end

    // window edges, widened so sums cannot wrap
    assign hds = {1'b0, horiz_display_start_r} +
                 (cfg_passive_r ? LCTP_HOFS_PASSIVE : LCTP_HOFS_ACTIVE);
    assign hde = {1'b0, hds} + {2'b00, horiz_display_width_r, 3'h7} + 12'h001;
    assign ls_beg = {1'b0, line_sync_start_r} + LCTP_LSYNC_OFS;
    assign hpe = {1'b0, ls_beg} + {5'h00, line_sync_width_r} + 12'h001;
    assign vde = {1'b0, vert_display_start_r} + {1'b0, vert_display_height_r} + 11'h001;
    assign vpe = {1'b0, frame_sync_start_r} + {8'h00, frame_sync_width_r} + 11'h001;

    assign h_active  = ({2'b00, hcount_r} >= {1'b0, hds}) && ({2'b00, hcount_r} < hde);
    assign v_active  = (vcount_r >= vert_display_start_r) && ({1'b0, vcount_r} < vde);
    assign ls_active = ({2'b00, hcount_r} >= {1'b0, ls_beg}) && ({2'b00, hcount_r} < hpe);
    assign fs_active = (vcount_r >= frame_sync_start_r) && ({1'b0, vcount_r} < vpe);

    // polarity setting is ignored for some active types; those drive active high
    assign ls_pol_used = (!cfg_passive_r &&
                          (cfg_type_r == LCTP_TFT_TYPE2 || cfg_type_r == LCTP_TFT_TYPE3)) ?
                         1'b1 : line_sync_pol_r;
    assign fs_pol_used = (!cfg_passive_r && cfg_type_r == LCTP_TFT_TYPE2) ?
                         1'b1 : frame_sync_pol_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            line_sync_out   <= 1'b0;
            frame_sync_out  <= 1'b0;
            display_enable  <= 1'b0;
            vert_nondisplay <= 1'b1;
        end
        else
        begin
            line_sync_out   <= ls_pol_used ? ls_active : !ls_active;
            frame_sync_out  <= fs_pol_used ? fs_active : !fs_active;
            display_enable  <= h_active && v_active;
            vert_nondisplay <= !v_active;
        end
    end
endmodule
`default_nettype wire

// ==== tb/lctp_props.sv ====
/* lctp_props: port-level checker for lctp_top.
   Assumes one clock domain and is attached by the bind after the module. */
`timescale 1ns/10ps
`default_nettype none
module lctp_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // panel timing
    input wire logic        line_sync_out,
    input wire logic        frame_sync_out,
    input wire logic        display_enable,
    input wire logic        vert_nondisplay
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic acc;
    assign acc = psel && penable;
    pready_high_a: assert property (pready) else $error("pready low");
    err_outside_a: assert property (!acc |-> !pslverr) else $error("stray pslverr");
    err_unmapped_a: assert property (acc && paddr == 8'h04 |-> pslverr)
        else $error("unmapped access not refused");
    err_mapped_a: assert property (acc && paddr == 8'h20 |-> !pslverr)
        else $error("mapped access refused");
    palw_zero_a: assert property (acc && !pwrite && paddr == 8'h18 |-> prdata == 32'h0)
        else $error("palette write port reads nonzero");
    de_in_vdisp_a: assert property (display_enable |-> !vert_nondisplay)
        else $error("display enable outside display lines");
    rdata_hold_a: assert property ((acc && !pwrite) ##1 !(psel && !pwrite) |-> $stable(prdata))
        else $error("read data moved");
    reset_out_a: assert property ($past(rst) |-> !display_enable && vert_nondisplay
        && !line_sync_out && !frame_sync_out && prdata == 32'h0) else $error("bad reset state");
    cover property (acc && pwrite && paddr == 8'h18);
    cover property ($rose(frame_sync_out));
    cover property (acc && pslverr);
    cover property ($fell(vert_nondisplay));
endmodule
bind lctp_top lctp_props u_props (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .line_sync_out(line_sync_out), .frame_sync_out(frame_sync_out),
    .display_enable(display_enable), .vert_nondisplay(vert_nondisplay)
);
`default_nettype wire

// ==== tb/lctp_panel_model.sv ====
/* lctp_panel_model: panel side that counts line pulses per frame.
   Assumes active-high syncs, as the bench programs them while it is read. */
`timescale 1ns/10ps
`default_nettype none
module lctp_panel_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // panel sync inputs
    input  wire logic       line_sync_out,
    input  wire logic       frame_sync_out,
    // lines seen in the last whole frame
    output logic      [9:0] line_count
);
    logic       ls_q_r;
    logic       fs_q_r;
    logic [9:0] run_r;
    logic       ls_rise;
    assign ls_rise = line_sync_out && !ls_q_r;
    always_ff @(posedge clk)
    begin
        ls_q_r <= line_sync_out;
        fs_q_r <= frame_sync_out;
        if (rst)
        begin
            run_r      <= 10'h0;
            line_count <= 10'h0;
        end
        else if (frame_sync_out && !fs_q_r)
        begin
            line_count <= run_r;
            run_r      <= {9'h0, ls_rise};
        end
        else
            run_r <= run_r + {9'h0, ls_rise};
    end
endmodule
`default_nettype wire

// ==== tb/tb_lcd_timing_and_palette_regs.sv ====
/* tb_lcd_timing_and_palette_regs: self-checking bench for lctp_top.
   Assumes the panel model and the bound checker are compiled beside it. */
`timescale 1ns/10ps
`default_nettype none
module tb_lcd_timing_and_palette_regs;
    logic        clk, rst, psel, penable, pwrite, strap, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, outs;
    logic        pready, pslverr, ls, fs, de, vnd;
    logic [9:0]  nlines;
    int          errors, checks, cyc, hi, per, n;
    assign outs = {vnd, de, fs, ls};
    lctp_top DUT (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .byte_order_strap(strap),
        .line_sync_out(ls), .frame_sync_out(fs), .display_enable(de),
        .vert_nondisplay(vnd)
    );
    lctp_panel_model u_panel (
        .clk(clk), .rst(rst), .line_sync_out(ls), .frame_sync_out(fs), .line_count(nlines)
    );
    always #5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            errors++;
            give_verdict;
        end
    end
    task automatic give_verdict;
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer, entered just after a rising edge, leaves one idle cycle
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [3:0] s);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] pe(input logic [7:0] i, input logic [7:0] x);
        return {x, i[5:0] ^ 6'h2a, 2'h0, ~i[5:0], 2'h0, i[7:2], 2'h0};
    endfunction
    // run length at level l and period of output s
    task automatic meas(input int s, input logic l);
        do @(negedge clk); while (outs[s] === l);
        do @(negedge clk); while (outs[s] !== l);
        hi = 0;
        do
        begin
            @(negedge clk);
            hi++;
        end while (outs[s] === l);
        per = hi;
        do
        begin
            @(negedge clk);
            per++;
        end while (outs[s] !== l);
    endtask
    // cycles from a rise of output a until output b reaches level lb
    task automatic gap(input int a, input int b, input logic lb);
        do @(negedge clk); while (outs[a] === 1'b1);
        do @(negedge clk); while (outs[a] !== 1'b1);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (outs[b] !== lb);
    endtask
    task automatic prog(input logic [31:0] v [9]);
        @(posedge clk);
        for (int i = 0; i < 9; i++)
            apb(i == 0 ? 8'h0c : 8'h1c + 8'(4 * i), 1'b1, v[i], 4'hf);
        repeat (400) @(posedge clk);
    endtask
    task automatic sc_palette;
        logic [7:0] idx [3] = '{8'h00, 8'h5a, 8'hff};
        foreach (idx[i])
        begin
            apb(8'h18, 1'b1, pe(idx[i], idx[i]), 4'hf);
            apb(8'h1c, 1'b0, 32'h0, 4'h0);
            chk("pal_auto_rd", pe(idx[i], 8'h00), rd);
        end
        apb(8'h1c, 1'b1, 32'h5a00_0000, 4'h8);
        apb(8'h1c, 1'b0, 32'h0, 4'h0);
        chk("pal_rd_idx", pe(8'h5a, 8'h00), rd);
        apb(8'h18, 1'b0, 32'h0, 4'h0);
        chk("pal_wr_rd", 32'h0, rd);
    endtask
    task automatic sc_regs;
        logic [7:0]  a [8] = '{8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h3c};
        logic [31:0] v [8] = '{32'h7f, 32'h55, 32'h3ff, 32'hff03ff, 32'h3ff, 32'h2aa,
                               32'h155, 32'h8703ff};
        foreach (a[i])
            apb(a[i], 1'b1, v[i], 4'hf);
        foreach (a[i])
        begin
            apb(a[i], 1'b0, 32'h0, 4'h0);
            chk("reg_rd", v[i], rd);
        end
        apb(8'h2c, 1'b1, 32'h0, 4'h4);
        apb(8'h2c, 1'b0, 32'h0, 4'h0);
        chk("lane_merge", 32'h0000_03ff, rd);
        apb(8'h04, 1'b0, 32'h0, 4'h0);
        chk("unmap_err", 32'h1, {31'h0, er});
        chk("unmap_rd", 32'h0, rd);
    endtask
    task automatic sc_bigend;
        strap <= 1'b1;
        rst   <= 1'b1;
        repeat (20) @(posedge clk);
        rst   <= 1'b0;
        repeat (6) @(posedge clk);
        apb(8'h14, 1'b0, 32'h0, 4'h0);
        chk("status", 32'h1, rd);
        apb(8'h18, 1'b1, pe(8'ha5, 8'h5a), 4'he);
        apb(8'h1c, 1'b0, 32'h0, 4'h0);
        chk("be_staged", pe(8'h5a, 8'h00), rd);
        apb(8'h18, 1'b1, pe(8'ha5, 8'h5a), 4'h1);
        apb(8'h1c, 1'b0, 32'h0, 4'h0);
        chk("be_commit", pe(8'ha5, 8'h00), rd);
    endtask
    task automatic sc_raster;
        prog('{0, 3, 1, 3, 32'h830002, 5, 1, 1, 32'h800004});
        meas(0, 1'b1);
        chk("ls_width", 4, hi);
        chk("ls_period", 32, per);
        meas(2, 1'b1);
        chk("de_width", 16, hi);
        gap(2, 0, 1'b1);
        chk("de_to_ls", 27, n);
        meas(1, 1'b1);
        chk("fs_width", 32, hi);
        chk("fs_period", 192, per);
        meas(3, 1'b1);
        chk("vnd_width", 128, hi);
        gap(1, 3, 1'b0);
        chk("fs_to_vdisp", 96, n);
        chk("lines", 6, nlines);
        prog('{1, 7, 3, 0, 32'h830002, 5, 1, 0, 32'h800000});
        meas(2, 1'b1);
        chk("pas_de_width", 32, hi);
        gap(2, 0, 1'b1);
        chk("pas_de_to_ls", 45, n);
        prog('{32'h10, 3, 1, 3, 32'h030002, 5, 1, 1, 32'h000004});
        meas(0, 1'b1);
        chk("t2_ls_high", 4, hi);
        meas(1, 1'b1);
        chk("t2_fs_high", 32, hi);
        prog('{32'h20, 3, 1, 3, 32'h030002, 5, 1, 1, 32'h000004});
        meas(0, 1'b1);
        chk("t3_ls_high", 4, hi);
        meas(1, 1'b0);
        chk("t3_fs_low", 32, hi);
        prog('{0, 3, 1, 3, 32'h030002, 5, 1, 1, 32'h000004});
        meas(0, 1'b0);
        chk("ls_low", 4, hi);
    endtask
    initial
    begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        strap = 1'b0;
        errors = 0;
        checks = 0;
        cyc = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        sc_palette;
        sc_regs;
        sc_bigend;
        sc_raster;
        give_verdict;
    end
endmodule
`default_nettype wire
